// File: rtl/pfda_core.sv
// module: program sequencer, return stack, table read and data addressing
//
// The APB interface to the registers was decided locally.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// [RULE1] eleven bit counter covers 2048 words
// [RULE2] counter advances by one per fetch
// [RULE3] true skip drops prefetch, one dummy
// [RULE4] low byte write jumps within page
// [RULE5] reset starts execution at zero
// [RULE6] taken interrupt loads its fixed vector
// [RULE7] jumps load target, returns load stack
// [RULE8] each non sequential change costs dummy
// [RULE9] table address from page and pointer
// [RULE10] table word splits to byte, high
// [RULE11] table read lasts two instruction cycles
// [RULE12] four deep hidden return stack
// [RULE13] stack pointer starts at top
// [RULE14] full stack holds interrupt unacknowledged
// [RULE15] call on full stack drops oldest
// [RULE16] unused low addresses read zero
// [RULE17] general ram 20H to 7FH, bit ops
// [RULE18] ports 00H, 02H go through pointers
// [RULE19] pointer at a port reads zero
// [RULE20] both pointers are seven bits
// [RULE21] accumulator sits at address 05H
// [RULE22] instruction cycle is four clocks
// [RULE23] low byte read shows counter bits
module pfda_core #(
	parameter int APB_ADDR_W = 12
) (
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	input  wire logic [APB_ADDR_W-1:0]         paddr,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [31:0]                   pwdata,
	output logic [31:0]                        prdata,
	output logic                               pready,
	output logic                               pslverr,
	input  wire logic                          cmd_valid,
	input  wire pfda_pkg::pfda_cmd_type        cmd_kind,
	input  wire logic [pfda_pkg::PC_W-1:0]     cmd_target,
	input  wire logic [pfda_pkg::DADDR_W-1:0]  cmd_dest,
	input  wire logic [pfda_pkg::IRQ_N-1:0]    irq_req,
	output logic [pfda_pkg::IRQ_N-1:0]         irq_ack,
	output logic [pfda_pkg::PC_W-1:0]          prog_addr,
	input  wire logic [pfda_pkg::PROG_W-1:0]   prog_data,
	output logic [pfda_pkg::PROG_W-1:0]        instr,
	output logic                               exec_valid,
	output logic                               cycle_end,
	output logic                               stack_full
);
	import pfda_pkg::*;

	pfda_regs_type       r;
	pfda_regs_type       n;
	pfda_cmd_type        eff_kind;
	logic                end_cyc;
	logic                irq_take;
	logic                cmd_go;
	logic [2:0]          irq_sel;
	logic                apb_first;
	logic                apb_done;
	logic                apb_bad;
	logic [DADDR_W-1:0]  apb_idx;
	logic [7:0]          apb_rval;
	logic [7:0]          apb_wval;
	logic [7:0]          bit_mask;

	// indirect ports fold onto the pointer contents
	function automatic logic [DADDR_W-1:0] resolve(
		input pfda_regs_type      s,
		input logic [DADDR_W-1:0] a
	);
		if (a == OFF_IND_A)
			return s.ptr_a; // [RULE18]
		if (a == OFF_IND_B)
			return s.ptr_b; // [RULE18]
		return a;
	endfunction : resolve

	// direct read; a port reached via a pointer lands in default
	function automatic logic [7:0] rd_direct(
		input pfda_regs_type      s,
		input logic [DADDR_W-1:0] a
	);
		logic [DADDR_W-1:0] idx;
		idx = a - OFF_RAM_BASE;
		case (a)
			OFF_PTR_A: return {1'b0, s.ptr_a};
			OFF_PTR_B: return {1'b0, s.ptr_b};
			OFF_ACC:   return s.acc; // [RULE21]
			OFF_PCL:   return s.pc[7:0]; // [RULE23]
			OFF_TPTR:  return s.tptr;
			OFF_THIGH: return s.thigh;
			default: begin
				if (a >= OFF_RAM_BASE)
					return s.ram[idx]; // [RULE17]
				return BYTE_RESET; // [RULE16] [RULE19]
			end
		endcase
	endfunction : rd_direct

	// direct write; ports, high byte and holes ignore it
	function automatic pfda_regs_type wr_direct(
		input pfda_regs_type      s,
		input logic [DADDR_W-1:0] a,
		input logic [7:0]         v
	);
		pfda_regs_type      o;
		logic [DADDR_W-1:0] idx;
		o = s;
		idx = a - OFF_RAM_BASE;
		case (a)
			OFF_PTR_A: o.ptr_a = v[DADDR_W-1:0]; // [RULE20]
			OFF_PTR_B: o.ptr_b = v[DADDR_W-1:0]; // [RULE20]
			OFF_ACC:   o.acc = v; // [RULE21]
			OFF_PCL: begin
				o.pcl_pend = 1'b1;
				o.pcl_val = v;
			end
			OFF_TPTR:  o.tptr = v;
			default: begin
				if (a >= OFF_RAM_BASE)
					o.ram[idx] = v; // [RULE17]
			end
		endcase
		return o; // [RULE19]
	endfunction : wr_direct

	// load the counter; a flush makes the next cycle a dummy
	function automatic pfda_regs_type pc_go(
		input pfda_regs_type   s,
		input logic [PC_W-1:0] t,
		input logic            flush
	);
		pfda_regs_type o;
		o = s;
		o.pc = t;
		o.prog_addr = t;
		o.exec_valid = !flush; // [RULE8]
		o.st = flush ? ST_DUMMY : ST_RUN;
		return o;
	endfunction : pc_go

	// push shifts the oldest entry out when full
	function automatic pfda_regs_type push(
		input pfda_regs_type   s,
		input logic [PC_W-1:0] ret
	);
		pfda_regs_type o;
		o = s;
		o.stack = {s.stack[STACK_DEPTH-2:0], ret}; // [RULE12]
		o.sp = s.full ? s.sp : s.sp + 3'h1; // [RULE15]
		return o;
	endfunction : push

	// next state of the whole core
	always_comb begin
		n = r;
		n.cycle_end = 1'b0;
		n.irq_ack = '0;
		end_cyc = (r.phase == PHASE_LAST); // [RULE22]
		n.phase = r.phase + 2'h1; // [RULE22]
		eff_kind = cmd_valid ? cmd_kind : CMD_SEQ;

		// lowest index has highest priority
		irq_sel = 3'h0;
		for (int i = IRQ_N - 1; i >= 0; i--) begin
			if (irq_req[i])
				irq_sel = 3'(i);
		end

		// irq only replaces a sequential step, so no
		// skip, jump or table command is ever lost
		irq_take = end_cyc && (r.st == ST_RUN) && !r.pcl_pend
			&& (|irq_req) && !r.full // [RULE14]
			&& (eff_kind == CMD_SEQ);
		cmd_go = end_cyc && (r.st == ST_RUN) && !r.pcl_pend
			&& !irq_take && cmd_valid;

		if (end_cyc) begin
			n.cycle_end = 1'b1;
			unique case (r.st)
				ST_TABLE: begin
					n = wr_direct(n, resolve(r, r.tab_dest), prog_data[7:0]); // [RULE10]
					n.thigh = {2'b00, prog_data[13:8]}; // [RULE10]
					n.st = ST_RUN; // [RULE11]
					n.exec_valid = 1'b1;
					n.prog_addr = r.pc;
				end
				ST_DUMMY: begin
					n.instr = prog_data;
					n = pc_go(n, r.pc + 11'h1, 1'b0); // [RULE2]
				end
				ST_RUN: begin
					n.instr = prog_data;
					if (r.pcl_pend) begin
						n.pcl_pend = 1'b0;
						n = pc_go(n, {r.pc[10:8], r.pcl_val}, 1'b1); // [RULE4]
					end else if (irq_take) begin
						n = push(n, r.pc); // [RULE12]
						n.irq_ack[irq_sel] = 1'b1;
						n = pc_go(n, IRQ_VEC[irq_sel], 1'b1); // [RULE6]
					end else begin
						unique case (eff_kind)
							CMD_SEQ: begin
								n = pc_go(n, r.pc + 11'h1, 1'b0); // [RULE2]
							end
							CMD_SKIP: begin
								// prefetched word dropped; dummy adds the second step
								n = pc_go(n, r.pc + 11'h1, 1'b1); // [RULE3]
							end
							CMD_JUMP: begin
								n = pc_go(n, cmd_target, 1'b1); // [RULE7]
							end
							CMD_CALL: begin
								n = push(n, r.pc); // [RULE15]
								n = pc_go(n, cmd_target, 1'b1); // [RULE7]
							end
							CMD_RET, CMD_RETURN_FROM_INTERRUPT: begin
								n.stack = {r.stack[STACK_DEPTH-1], r.stack[STACK_DEPTH-1:1]};
								n.sp = (r.sp == SP_RESET) ? SP_RESET : r.sp - 3'h1; // [RULE12]
								n = pc_go(n, r.stack[0], 1'b1); // [RULE7]
							end
							CMD_TAB_CUR, CMD_TAB_LAST: begin
								// next word is held in instr across the table cycle
								n.tab_addr = {(eff_kind == CMD_TAB_LAST) ? LAST_PAGE : r.pc[10:8],
									r.tptr}; // [RULE9]
								n.tab_dest = cmd_dest;
								n.st = ST_TABLE; // [RULE11]
								n.exec_valid = 1'b0;
								n.pc = r.pc + 11'h1;
								n.prog_addr = n.tab_addr;
							end
						endcase
					end
				end
			endcase
		end
		n.full = (n.sp == SP_FULL);

		// apb slave, one wait state so outputs stay registered
		apb_idx = paddr[APB_IDX_LSB +: DADDR_W];
		apb_bad = |paddr[APB_ADDR_W-1:APB_IDX_LSB+DADDR_W];
		apb_rval = rd_direct(r, resolve(r, apb_idx)); // [RULE18]
		bit_mask = 8'h01 << pwdata[BITSEL_LSB +: 3];
		case (pwdata[WMODE_LSB +: 2])
			WMODE_SET: apb_wval = apb_rval | bit_mask; // [RULE17]
			WMODE_CLR: apb_wval = apb_rval & ~bit_mask; // [RULE17]
			default:   apb_wval = pwdata[7:0];
		endcase
		apb_first = psel && penable && !r.pready;
		apb_done = psel && penable && r.pready;

		// placed after the cycle end so a new pcl write is not lost
		if (apb_first) begin
			n.pready = 1'b1;
			n.pslverr = apb_bad;
			n.prdata = {24'h000000, apb_bad ? BYTE_RESET : apb_rval};
		end else if (apb_done) begin
			n.pready = 1'b0;
			n.pslverr = 1'b0;
			if (pwrite && !r.pslverr)
				n = wr_direct(n, resolve(r, apb_idx), apb_wval); // [RULE18]
		end
	end

	// single state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			r <= REGS_RESET; // [RULE5] [RULE13]
		else
			r <= n;
	end

	// outputs straight from the state register
	assign prdata     = r.prdata;
	assign pready     = r.pready;
	assign pslverr    = r.pslverr;
	assign irq_ack    = r.irq_ack;
	assign prog_addr  = r.prog_addr; // [RULE1]
	assign instr      = r.instr;
	assign exec_valid = r.exec_valid;
	assign cycle_end  = r.cycle_end;
	assign stack_full = r.full;

	// checks
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	property p_width;
		(r.sp <= SP_FULL) && (r.prog_addr < 12'h800);
	endproperty
	a_width: assert property (p_width) else $error("counter or stack pointer out of range"); // [RULE1]

	property p_seq;
		cmd_go && (eff_kind == CMD_SEQ) |=> (r.pc == $past(r.pc) + 11'h1) && r.exec_valid;
	endproperty
	a_seq: assert property (p_seq) else $error("sequential step wrong"); // [RULE2]

	property p_skip;
		cmd_go && (eff_kind == CMD_SKIP) |=> !r.exec_valid ##4 (r.pc == $past(r.pc, 5) + 11'h2);
	endproperty
	a_skip: assert property (p_skip) else $error("skip did not advance by two"); // [RULE3]

	property p_pcl;
		end_cyc && (r.st == ST_RUN) && r.pcl_pend
			|=> (r.pc == {$past(r.pc[10:8]), $past(r.pcl_val)}) && !r.exec_valid;
	endproperty
	a_pcl: assert property (p_pcl) else $error("short jump wrong"); // [RULE4]

	property p_reset;
		!$past(presetn) |-> (r.pc == PC_RESET) && (r.prog_addr == PC_RESET);
	endproperty
	a_reset: assert property (p_reset) else $error("counter not zero after reset"); // [RULE5]

	property p_sp_reset;
		!$past(presetn) |-> (r.sp == SP_RESET) && !stack_full;
	endproperty
	a_sp_reset: assert property (p_sp_reset) else $error("stack pointer not at top"); // [RULE13]

	property p_vec;
		irq_take |=> (r.pc == IRQ_VEC[$past(irq_sel)]) && (irq_ack != '0) && !r.exec_valid;
	endproperty
	a_vec: assert property (p_vec) else $error("wrong interrupt vector"); // [RULE6]

	property p_jump;
		cmd_go && (eff_kind == CMD_JUMP) |=> r.pc == $past(cmd_target);
	endproperty
	a_jump: assert property (p_jump) else $error("jump target wrong"); // [RULE7]

	property p_ret;
		cmd_go && ((eff_kind == CMD_RET) || (eff_kind == CMD_RETURN_FROM_INTERRUPT)) |=> r.pc == $past(r.stack[0]);
	endproperty
	a_ret: assert property (p_ret) else $error("return address wrong"); // [RULE7]

	property p_dummy;
		cmd_go && ((eff_kind == CMD_JUMP) || (eff_kind == CMD_CALL))
			|=> !r.exec_valid [*4] ##1 r.exec_valid;
	endproperty
	a_dummy: assert property (p_dummy) else $error("dummy cycle length wrong"); // [RULE8]

	property p_tab;
		cmd_go && (eff_kind == CMD_TAB_LAST)
			|=> (r.prog_addr == {LAST_PAGE, $past(r.tptr)}) [*4] ##1 r.exec_valid;
	endproperty
	a_tab: assert property (p_tab) else $error("table read address or length wrong"); // [RULE11]

	property p_thigh;
		end_cyc && (r.st == ST_TABLE) |=> r.thigh == {2'b00, $past(prog_data[13:8])};
	endproperty
	a_thigh: assert property (p_thigh) else $error("table high byte wrong"); // [RULE10]

	property p_full;
		end_cyc && r.full |=> irq_ack == '0;
	endproperty
	a_full: assert property (p_full) else $error("interrupt taken on full stack"); // [RULE14]

	property p_ovf;
		cmd_go && (eff_kind == CMD_CALL) && r.full
			|=> (r.sp == SP_FULL) && (r.stack[0] == $past(r.pc)) && (r.stack[3] == $past(r.stack[2]));
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflowing call wrong"); // [RULE15]

	property p_hole;
		apb_first && !apb_bad && (apb_idx > OFF_THIGH) && (apb_idx < OFF_RAM_BASE)
			|=> prdata == 32'h00000000;
	endproperty
	a_hole: assert property (p_hole) else $error("hole did not read zero"); // [RULE16]

	c_irq: cover property (irq_take);
	c_call_ret: cover property (cmd_go && (eff_kind == CMD_CALL) ##[1:40] cmd_go && (eff_kind == CMD_RET));
	c_table: cover property (cmd_go && (eff_kind == CMD_TAB_CUR));
	c_ovf: cover property (cmd_go && (eff_kind == CMD_CALL) && r.full);

endmodule : pfda_core

`default_nettype wire

// File: rtl/pfda_pkg.sv
// package: constants and types of the program flow and data addressing core
package pfda_pkg;

	// widths and sizes
	localparam int PC_W        = 11;
	localparam int PROG_W      = 14;
	localparam int DADDR_W     = 7;
	localparam int STACK_DEPTH = 4;
	localparam int IRQ_N       = 5;
	localparam int RAM_WORDS   = 96;
	localparam int APB_IDX_LSB = 2;
	localparam int WMODE_LSB   = 8;
	localparam int BITSEL_LSB  = 0;

	// four system clocks per instruction cycle
	localparam logic [1:0] PHASE_LAST = 2'h3;

	// data address map, byte address on apb is four times these
	localparam logic [6:0] OFF_IND_A    = 7'h00;
	localparam logic [6:0] OFF_PTR_A    = 7'h01;
	localparam logic [6:0] OFF_IND_B    = 7'h02;
	localparam logic [6:0] OFF_PTR_B    = 7'h03;
	localparam logic [6:0] OFF_ACC      = 7'h05;
	localparam logic [6:0] OFF_PCL      = 7'h06;
	localparam logic [6:0] OFF_TPTR     = 7'h07;
	localparam logic [6:0] OFF_THIGH    = 7'h08;
	localparam logic [6:0] OFF_RAM_BASE = 7'h20;

	// program memory pages and vectors
	localparam logic [2:0]  LAST_PAGE = 3'h7;
	localparam logic [10:0] PC_RESET  = 11'h000;
	localparam logic [2:0]  SP_RESET  = 3'h0;
	localparam logic [2:0]  SP_FULL   = 3'h4;
	localparam logic [7:0]  BYTE_RESET = 8'h00;
	localparam logic [IRQ_N-1:0][PC_W-1:0] IRQ_VEC =
		{11'h014, 11'h010, 11'h00C, 11'h008, 11'h004};

	// apb write modes in pwdata[9:8]
	localparam logic [1:0] WMODE_SET = 2'h1;
	localparam logic [1:0] WMODE_CLR = 2'h2;

	typedef enum logic [2:0] {
		ST_RUN   = 3'b001,
		ST_DUMMY = 3'b010,
		ST_TABLE = 3'b100
	} pfda_state_type;

	typedef enum logic [2:0] {
		CMD_SEQ      = 3'h0,
		CMD_SKIP     = 3'h1,
		CMD_JUMP     = 3'h2,
		CMD_CALL     = 3'h3,
		CMD_RET      = 3'h4,
		CMD_RETURN_FROM_INTERRUPT     = 3'h5,
		CMD_TAB_CUR  = 3'h6,
		CMD_TAB_LAST = 3'h7
	} pfda_cmd_type;

	typedef struct packed {
		pfda_state_type                    st;
		logic [1:0]                        phase;
		logic [PC_W-1:0]                   pc;
		logic [STACK_DEPTH-1:0][PC_W-1:0]  stack;
		logic [2:0]                        sp;
		logic                              full;
		logic [DADDR_W-1:0]                ptr_a;
		logic [DADDR_W-1:0]                ptr_b;
		logic [7:0]                        acc;
		logic [7:0]                        tptr;
		logic [7:0]                        thigh;
		logic [RAM_WORDS-1:0][7:0]         ram;
		logic                              pcl_pend;
		logic [7:0]                        pcl_val;
		logic [PC_W-1:0]                   tab_addr;
		logic [DADDR_W-1:0]                tab_dest;
		logic [PC_W-1:0]                   prog_addr;
		logic [PROG_W-1:0]                 instr;
		logic                              exec_valid;
		logic                              cycle_end;
		logic [IRQ_N-1:0]                  irq_ack;
		logic                              pready;
		logic                              pslverr;
		logic [31:0]                       prdata;
	} pfda_regs_type;

	localparam pfda_regs_type REGS_RESET = '{
		st: ST_RUN, pc: PC_RESET, sp: SP_RESET, default: '0};

endpackage : pfda_pkg

// File: testbench/pfda_core_tb.sv
// testbench: self-checking bench of the sequencer, stack, table read and data addressing core
`timescale 1ns/100ps
`default_nettype none
module pfda_core_tb;
	import pfda_pkg::*;

	logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
	logic         cmd_valid, exec_valid, cycle_end, stack_full;
	logic [11:0]  paddr;
	logic [31:0]  pwdata, prdata, rdat;
	pfda_cmd_type cmd_kind;
	logic [10:0]  cmd_target, prog_addr, at;
	logic [10:0]  rets [5];
	logic [6:0]   cmd_dest;
	logic [4:0]   irq_req, irq_ack;
	logic [13:0]  prog_data, instr;
	int           mismatches, compares, acks;
	time          t0;

	// program memory image: every word differs from its neighbours
	function automatic logic [13:0] pm(input logic [10:0] a);
		return {a[5:0] ^ 6'h2A, a[7:0]};
	endfunction : pm

	function automatic logic [11:0] ad(input logic [6:0] i);
		return {3'h0, i, 2'h0};
	endfunction : ad

	assign prog_data = pm(prog_addr);

	pfda_core dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_target(cmd_target), .cmd_dest(cmd_dest),
		.irq_req(irq_req), .irq_ack(irq_ack), .prog_addr(prog_addr), .prog_data(prog_data),
		.instr(instr), .exec_valid(exec_valid), .cycle_end(cycle_end), .stack_full(stack_full));

	// 25 MHz clock
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	// count every acknowledge pulse
	always @(posedge pclk) begin
		if (irq_ack !== 5'h00) acks++;
	end

	task end_sim;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_sim

	task fail;
		mismatches++;
		$display("Error at %0t: wait timed out", $time);
		end_sim();
	endtask : fail

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: check %0d seen %h expected %h", $time, compares, seen, exp);
		end
	endtask : chk

	// wait for a cycle end, optionally one that starts a real instruction
	task sync(input logic need);
		int n;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (!(cycle_end === 1'b1 && (exec_valid === 1'b1 || !need)) && n < 40);
		if (n >= 40) fail();
	endtask : sync

	// command held from phase 1 until the cycle end that takes it
	task step(input pfda_cmd_type k, input logic [10:0] t, input logic [6:0] d);
		sync(1'b1);
		at = prog_addr;
		cmd_valid <= 1'b1;
		cmd_kind <= k;
		cmd_target <= t;
		cmd_dest <= d;
		sync(1'b0);
		cmd_valid <= 1'b0;
	endtask : step

	// one apb transfer, held until pready is sampled high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) fail();
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task take(input int i);
		int n;
		irq_req <= 5'(1 << i);
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (irq_ack === 5'h00 && n < 40);
		if (n >= 40) fail();
		chk(32'(irq_ack), 32'(1 << i));
		chk(32'(prog_addr), 32'((i + 1) * 4));
		irq_req <= 5'h00;
	endtask : take

	task t_reset;
		repeat (8) @(posedge pclk);
		chk(32'(prog_addr), 32'h0);
		chk(32'(stack_full), 32'h0);
		presetn <= 1'b1;
		sync(1'b0);
		t0 = $time;
		chk(32'(instr), 32'(pm(11'h000)));
		chk(32'(prog_addr), 32'h1);
		sync(1'b0);
		chk(32'($time - t0), 32'hA0);
		$display("test reset done");
	endtask : t_reset

	task t_flow;
		step(CMD_JUMP, 11'h7FE, 7'h00);
		chk(32'(prog_addr), 32'h7FE);
		chk(32'(exec_valid), 32'h0);
		sync(1'b0);
		chk(32'(instr), 32'(pm(11'h7FE)));
		sync(1'b0);
		chk(32'(prog_addr), 32'h0);
		step(CMD_JUMP, 11'h300, 7'h00);
		step(CMD_SKIP, 11'h000, 7'h00);
		chk(32'(prog_addr), 32'h302);
		chk(32'(exec_valid), 32'h0);
		sync(1'b0);
		chk(32'(instr), 32'(pm(11'h302)));
		sync(1'b0);
		// the answer is formed after the next cycle end, so the counter has stepped to 305
		repeat (2) @(posedge pclk);
		apb(1'b0, ad(OFF_PCL), 32'h0);
		chk(rdat, 32'h05);
		$display("test flow done");
	endtask : t_flow

	task t_table;
		apb(1'b1, ad(OFF_TPTR), 32'hA5);
		step(CMD_TAB_CUR, 11'h000, 7'h20);
		chk(32'(prog_addr), 32'h3A5);
		chk(32'(exec_valid), 32'h0);
		sync(1'b0);
		chk(32'(exec_valid), 32'h1);
		apb(1'b0, ad(7'h20), 32'h0);
		chk(rdat, 32'(pm(11'h3A5) & 14'h00FF));
		apb(1'b1, ad(OFF_THIGH), 32'hFF);
		apb(1'b0, ad(OFF_THIGH), 32'h0);
		chk(rdat, 32'(pm(11'h3A5) >> 8));
		apb(1'b1, ad(OFF_PTR_A), 32'h21);
		step(CMD_TAB_LAST, 11'h000, 7'h00);
		chk(32'(prog_addr), 32'h7A5);
		sync(1'b0);
		apb(1'b0, ad(7'h21), 32'h0);
		chk(rdat, 32'(pm(11'h7A5) & 14'h00FF));
		$display("test table done");
	endtask : t_table

	task t_pcl;
		int n;
		apb(1'b1, ad(OFF_PCL), 32'h34);
		n = 0;
		do begin
			sync(1'b0);
			n++;
		end while (exec_valid !== 1'b0 && n < 4);
		chk(32'(prog_addr), 32'h334);
		$display("test low byte jump done");
	endtask : t_pcl

	task t_stack;
		for (int i = 0; i < 5; i++) begin
			step(CMD_CALL, 11'h100 + 11'(i << 4), 7'h00);
			rets[i] = at;
			chk(32'(prog_addr), 32'h100 + 32'(i << 4));
			chk(32'(stack_full), 32'(i >= 3));
		end
		// full stack: request waits without acknowledge
		irq_req <= 5'h01;
		step(CMD_SEQ, 11'h000, 7'h00);
		step(CMD_SEQ, 11'h000, 7'h00);
		chk(32'(acks), 32'h0);
		step(CMD_RET, 11'h000, 7'h00);
		chk(32'(prog_addr), 32'(rets[4]));
		take(0);
		step(CMD_RETURN_FROM_INTERRUPT, 11'h000, 7'h00);
		for (int i = 3; i > 0; i--) begin
			step(CMD_RET, 11'h000, 7'h00);
			chk(32'(prog_addr), 32'(rets[i]));
		end
		chk(32'(stack_full), 32'h0);
		for (int i = 1; i < 5; i++) begin
			take(i);
			step(CMD_RETURN_FROM_INTERRUPT, 11'h000, 7'h00);
		end
		$display("test stack and vectors done");
	endtask : t_stack

	task t_data;
		apb(1'b1, ad(OFF_ACC), 32'h5C);
		apb(1'b0, ad(OFF_ACC), 32'h0);
		chk(rdat, 32'h5C);
		apb(1'b1, ad(7'h10), 32'hFF);
		apb(1'b0, ad(7'h10), 32'h0);
		chk(rdat, 32'h0);
		// byte write, set bit 3, clear bit 0
		apb(1'b1, ad(7'h7F), 32'h81);
		apb(1'b1, ad(7'h7F), 32'h103);
		apb(1'b1, ad(7'h7F), 32'h200);
		apb(1'b0, ad(7'h7F), 32'h0);
		chk(rdat, 32'h88);
		apb(1'b1, ad(OFF_PTR_B), 32'hFF);
		apb(1'b0, ad(OFF_PTR_B), 32'h0);
		chk(rdat, 32'h7F);
		apb(1'b1, ad(OFF_IND_B), 32'h66);
		apb(1'b0, ad(7'h7F), 32'h0);
		chk(rdat, 32'h66);
		apb(1'b1, ad(OFF_PTR_B), 32'h02);
		apb(1'b1, ad(OFF_IND_B), 32'h11);
		apb(1'b0, ad(OFF_IND_B), 32'h0);
		chk(rdat, 32'h0);
		apb(1'b0, 12'hE00, 32'h0);
		chk(32'(rerr), 32'h1);
		chk(rdat, 32'h0);
		$display("test data addressing done");
	endtask : t_data

	// main sequence
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		cmd_valid = 1'b0;
		cmd_kind = CMD_SEQ;
		cmd_target = 11'h000;
		cmd_dest = 7'h00;
		irq_req = 5'h00;
		mismatches = 0;
		compares = 0;
		acks = 0;
		t_reset();
		t_flow();
		t_table();
		t_pcl();
		t_stack();
		t_data();
		// reset in mid-run with a full stack, then a clean restart
		for (int i = 0; i < 4; i++)
			step(CMD_CALL, 11'h155, 7'h00);
		chk(32'(stack_full), 32'h1);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk(32'(prog_addr), 32'h0);
		chk(32'(stack_full), 32'h0);
		presetn <= 1'b1;
		sync(1'b0);
		chk(32'(instr), 32'(pm(11'h000)));
		chk(32'(prog_addr), 32'h1);
		$display("test mid-run reset done");
		end_sim();
	end
endmodule : pfda_core_tb
`default_nettype wire
